// *** design/flash_fault_pkg.sv ***
// Package holding the register map, field layout and carriers of the flash fault configuration block
package flash_fault_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;

  // Printed offsets are not word multiples, so they are indices and byte address is 4x index
  localparam logic [ADDR_W-1:0] IDX_FLASH_CONFIG = 16'h3024;
  localparam logic [ADDR_W-1:0] IDX_FAULT_IRQ_CONFIG = 16'h3025;
  localparam logic [ADDR_W-1:0] IDX_FAULT_STATUS = 16'h3026;
  localparam logic [ADDR_W-1:0] IDX_FLASH_STATUS = 16'h3027;

  localparam logic [ADDR_W-1:0] ADDR_FLASH_CONFIG = {IDX_FLASH_CONFIG[ADDR_W-3:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_FAULT_IRQ_CONFIG = {IDX_FAULT_IRQ_CONFIG[ADDR_W-3:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_FAULT_STATUS = {IDX_FAULT_STATUS[ADDR_W-3:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_FLASH_STATUS = {IDX_FLASH_STATUS[ADDR_W-3:0], 2'h0};

  // Field positions of the flash configuration register
  localparam int CFG_CMD_DONE_IRQ_EN = 7;
  localparam int CFG_IGNORE_SINGLE_FAULT = 4;
  localparam int CFG_FORCE_DOUBLE_FAULT = 1;
  localparam int CFG_FORCE_SINGLE_FAULT = 0;
  localparam logic [REG_W-1:0] CFG_WRITE_MASK = 8'h93;
  localparam logic [REG_W-1:0] CFG_RESET = 8'h00;

  // Field positions of the fault interrupt configuration register
  localparam int ERR_DOUBLE_FAULT_IRQ_EN = 1;
  localparam int ERR_SINGLE_FAULT_IRQ_EN = 0;
  localparam logic [REG_W-1:0] ERR_WRITE_MASK = 8'h03;
  localparam logic [REG_W-1:0] ERR_RESET = 8'h00;

  // Status layout: fault status bits 1..0, command done bit 7 of flash status
  localparam int STAT_DOUBLE_FAULT = 1;
  localparam int STAT_SINGLE_FAULT = 0;
  localparam int STAT_CMD_DONE = 7;

  // Flag vector indices
  localparam int NUM_FLAGS = 3;
  localparam int FLAG_SINGLE = 0;
  localparam int FLAG_DOUBLE = 1;
  localparam int FLAG_CMD_DONE = 2;
  // Command done reads 1 after reset: no command in progress
  localparam logic [NUM_FLAGS-1:0] FLAG_RESET = 3'h4;

  typedef struct packed {
    logic readStrobe;
    logic singleErr;
    logic doubleErr;
  } array_read_s;

  typedef struct packed {
    logic cmdDone;
    logic doubleFault;
    logic singleFault;
  } irq_s;

endpackage

// *** design/sticky_flag_bank.sv ***
// Bank of sticky status flags where a set in the same cycle beats a clear
`timescale 1ns/1ps
module sticky_flag_bank #(
  parameter int N = 3,
  parameter logic [N-1:0] RESET_VAL = '0
) (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic [N-1:0] setReq, // One-cycle set pulses
  input wire logic [N-1:0] clrReq, // One-cycle clear pulses
  output logic [N-1:0] flags // Registered flag levels
);

  logic [N-1:0] flags_q;
  logic [N-1:0] flags_d;

  always_comb begin
    for (int i = 0; i < N; i++) begin
      // Set wins so an event coinciding with a clear is never lost
      flags_d[i] = setReq[i] | (flags_q[i] & ~clrReq[i]);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flags_q <= RESET_VAL;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags = flags_q;

endmodule

// *** design/flash_fault_irq_config.sv ***
// APB configuration and fault flag logic of the flash controller interrupt and ECC fault paths
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
// Functional notes
// R1: Command-done interrupt requested while its enable bit 7 and the done flag are set.
// R2: Reserved bits 6..5, 3..2 and 7..2 read zero and ignore writes.
// R3: Ignore bit 4 clear: every real single-bit read fault is reported.
// R4: Ignore bit set: real single-bit faults neither reported nor interrupting.
// R5: Force-double bit 1 set: every array read sets the double-fault flag.
// R6: Force-double clear: double flag set only on a detected double fault.
// R7: Force-double bit persists across reads until software writes zero.
// R8: Force-single bit 0 set: every array read sets the single-fault flag.
// R9: Force-single clear: single flag set only on a real single fault.
// R10: Force-single bit persists until software writes zero to it.
// R11: Double-fault interrupt enable bit 1 gates double-fault interrupt request.
// R12: Single-fault interrupt enable bit 0 gates single-fault interrupt request.
// R13: Flash configuration register decoded at index 4 above base, 3024h.
// R14: Fault interrupt configuration register decoded at index 5 above base, 3025h.
// R15: Done flag set on command finish, cleared by writing 1 to launch.
// R16: Each interrupt request is a level while flag and enable are both set.
module flash_fault_irq_config (
  input wire logic clk_sys, // System clock, 25 MHz
  input wire logic rst, // Async reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write direction
  input wire logic [flash_fault_pkg::ADDR_W-1:0] paddr, // APB byte address
  input wire logic [flash_fault_pkg::DATA_W-1:0] pwdata, // APB write data
  output logic [flash_fault_pkg::DATA_W-1:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire flash_fault_pkg::array_read_s arrayRead, // Array read strobe with ECC results
  input wire logic cmdFinish, // Pulse when a flash command completes
  output logic cmdLaunch, // Pulse when software launches a command
  output logic ignoreSingleFault, // Current ignore-single setting
  output flash_fault_pkg::irq_s irq // Interrupt request levels
);

  logic [flash_fault_pkg::REG_W-1:0] config_q;
  logic [flash_fault_pkg::REG_W-1:0] config_d;
  logic [flash_fault_pkg::REG_W-1:0] errConfig_q;
  logic [flash_fault_pkg::REG_W-1:0] errConfig_d;
  logic [flash_fault_pkg::DATA_W-1:0] rdata_q;
  logic [flash_fault_pkg::DATA_W-1:0] rdata_d;
  logic launch_q;
  logic launch_d;
  logic [flash_fault_pkg::NUM_FLAGS-1:0] flagSet;
  logic [flash_fault_pkg::NUM_FLAGS-1:0] flagClr;
  logic [flash_fault_pkg::NUM_FLAGS-1:0] flags;
  logic setupPhase;
  logic writeAccess;
  logic [flash_fault_pkg::REG_W-1:0] wrByte;

  // Address decode for the error answer; read mux and write strobes compare paddr directly
  function automatic logic addrHit(input logic [flash_fault_pkg::ADDR_W-1:0] a);
    addrHit = (a == flash_fault_pkg::ADDR_FLASH_CONFIG) ||
              (a == flash_fault_pkg::ADDR_FAULT_IRQ_CONFIG) ||
              (a == flash_fault_pkg::ADDR_FAULT_STATUS) ||
              (a == flash_fault_pkg::ADDR_FLASH_STATUS);
  endfunction

  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign setupPhase = psel & ~penable;
  assign writeAccess = psel & penable & pwrite;
  assign wrByte = pwdata[flash_fault_pkg::REG_W-1:0];
  assign pslverr = psel & penable & ~addrHit(paddr);

  // Configuration registers; reserved bits are masked out on write R2
  always_comb begin
    config_d = config_q;
    errConfig_d = errConfig_q;
    if (writeAccess && paddr == flash_fault_pkg::ADDR_FLASH_CONFIG) begin // R13
      // Force bits only change on a software write, never by a read R7 R10
      config_d = wrByte & flash_fault_pkg::CFG_WRITE_MASK; // R2
    end
    if (writeAccess && paddr == flash_fault_pkg::ADDR_FAULT_IRQ_CONFIG) begin // R14
      errConfig_d = wrByte & flash_fault_pkg::ERR_WRITE_MASK; // R2
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      config_q <= flash_fault_pkg::CFG_RESET;
      errConfig_q <= flash_fault_pkg::ERR_RESET;
    end else begin
      config_q <= config_d;
      errConfig_q <= errConfig_d;
    end
  end

  // Flag set and clear requests
  always_comb begin
    flagSet = '0;
    flagClr = '0;
    launch_d = 1'b0;
    // Forced faults ignore the ignore bit: a test of the handler must always fire
    flagSet[flash_fault_pkg::FLAG_SINGLE] = arrayRead.readStrobe &
      (config_q[flash_fault_pkg::CFG_FORCE_SINGLE_FAULT] | // R8
       (arrayRead.singleErr & ~config_q[flash_fault_pkg::CFG_IGNORE_SINGLE_FAULT])); // R3 R4 R9
    flagSet[flash_fault_pkg::FLAG_DOUBLE] = arrayRead.readStrobe &
      (config_q[flash_fault_pkg::CFG_FORCE_DOUBLE_FAULT] | arrayRead.doubleErr); // R5 R6
    flagSet[flash_fault_pkg::FLAG_CMD_DONE] = cmdFinish; // R15
    if (writeAccess && paddr == flash_fault_pkg::ADDR_FAULT_STATUS) begin
      flagClr[flash_fault_pkg::FLAG_SINGLE] = wrByte[flash_fault_pkg::STAT_SINGLE_FAULT];
      flagClr[flash_fault_pkg::FLAG_DOUBLE] = wrByte[flash_fault_pkg::STAT_DOUBLE_FAULT];
    end
    // A launch is only accepted while no command is in progress
    if (writeAccess && paddr == flash_fault_pkg::ADDR_FLASH_STATUS &&
        wrByte[flash_fault_pkg::STAT_CMD_DONE] && flags[flash_fault_pkg::FLAG_CMD_DONE]) begin
      flagClr[flash_fault_pkg::FLAG_CMD_DONE] = 1'b1; // R15
      launch_d = 1'b1;
    end
  end

  sticky_flag_bank #(
    .N(flash_fault_pkg::NUM_FLAGS),
    .RESET_VAL(flash_fault_pkg::FLAG_RESET)
  ) u_flags (
    .clk_sys(clk_sys),
    .rst(rst),
    .setReq(flagSet),
    .clrReq(flagClr),
    .flags(flags)
  );

  // Read data is captured in the setup cycle so prdata comes from a flop
  always_comb begin
    rdata_d = rdata_q;
    if (setupPhase) begin
      rdata_d = '0;
      if (!pwrite) begin
        unique case (paddr)
          flash_fault_pkg::ADDR_FLASH_CONFIG: begin
            rdata_d[flash_fault_pkg::REG_W-1:0] = config_q; // R2
          end
          flash_fault_pkg::ADDR_FAULT_IRQ_CONFIG: begin
            rdata_d[flash_fault_pkg::REG_W-1:0] = errConfig_q; // R2
          end
          flash_fault_pkg::ADDR_FAULT_STATUS: begin
            rdata_d[flash_fault_pkg::STAT_SINGLE_FAULT] = flags[flash_fault_pkg::FLAG_SINGLE];
            rdata_d[flash_fault_pkg::STAT_DOUBLE_FAULT] = flags[flash_fault_pkg::FLAG_DOUBLE];
          end
          flash_fault_pkg::ADDR_FLASH_STATUS: begin
            rdata_d[flash_fault_pkg::STAT_CMD_DONE] = flags[flash_fault_pkg::FLAG_CMD_DONE];
          end
          default: begin
            rdata_d = '0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_q <= '0;
      launch_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      launch_q <= launch_d;
    end
  end

  assign prdata = rdata_q;
  assign cmdLaunch = launch_q;
  assign ignoreSingleFault = config_q[flash_fault_pkg::CFG_IGNORE_SINGLE_FAULT];

  // Requests are levels from flops, dropping as soon as flag or enable clears
  assign irq.cmdDone = flags[flash_fault_pkg::FLAG_CMD_DONE] &
    config_q[flash_fault_pkg::CFG_CMD_DONE_IRQ_EN]; // R1 R16
  assign irq.doubleFault = flags[flash_fault_pkg::FLAG_DOUBLE] &
    errConfig_q[flash_fault_pkg::ERR_DOUBLE_FAULT_IRQ_EN]; // R11 R5 R16
  assign irq.singleFault = flags[flash_fault_pkg::FLAG_SINGLE] &
    errConfig_q[flash_fault_pkg::ERR_SINGLE_FAULT_IRQ_EN]; // R12 R4 R8 R16

endmodule

// *** verification/flash_fault_irq_config_props.sv ***
// Port checker for the flash fault configuration block
`timescale 1ns/1ps
module flash_fault_irq_config_props (
  input wire logic clk_sys, // Clock
  input wire logic rst, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [15:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire flash_fault_pkg::array_read_s arrayRead, // Array read
  input wire logic cmdFinish, // Finish
  input wire logic cmdLaunch, // Launch
  input wire logic ignoreSingleFault, // Ignore level
  input wire flash_fault_pkg::irq_s irq // Requests
);
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic [7:0] err_q;
  logic [7:0] err_d;
  logic wr;
  logic rdAcc;
  assign wr = psel && penable && pwrite;
  assign rdAcc = psel && penable && !pwrite;
  // Shadow copies of both registers, masked to their writable bits
  always_comb begin
    cfg_d = cfg_q;
    err_d = err_q;
    if (wr && paddr == 16'hC090) begin
      cfg_d = pwdata[7:0] & 8'h93;
    end
    if (wr && paddr == 16'hC094) begin
      err_d = pwdata[7:0] & 8'h03;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg_q <= 8'h00;
      err_q <= 8'h00;
    end else begin
      cfg_q <= cfg_d;
      err_q <= err_d;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_CMD_IRQ: assert property (cmdFinish |=> irq.cmdDone == cfg_q[7])
    else $error("command done request wrong after finish");
  AST_CFG_READ: assert property (rdAcc && paddr == 16'hC090 |-> prdata == {24'h0, cfg_q})
    else $error("flash config read wrong");
  AST_ERR_READ: assert property (rdAcc && paddr == 16'hC094 |-> prdata == {24'h0, err_q})
    else $error("fault irq config read wrong");
  AST_FORCE_DBL: assert property (arrayRead.readStrobe && cfg_q[1] |=>
    irq.doubleFault == err_q[1])
    else $error("forced double fault missing");
  AST_FORCE_SGL: assert property (arrayRead.readStrobe && cfg_q[0] |=>
    irq.singleFault == err_q[0])
    else $error("forced single fault missing");
  AST_REAL_DBL: assert property (arrayRead.readStrobe && arrayRead.doubleErr |=>
    irq.doubleFault == err_q[1])
    else $error("double fault not raised");
  AST_SGL_CAUSE: assert property ($rose(irq.singleFault) && $past(err_q[0]) |->
    $past(arrayRead.readStrobe && (cfg_q[0] || arrayRead.singleErr && !cfg_q[4])))
    else $error("single fault raised without cause");
  AST_DBL_GATE: assert property (!err_q[1] |-> !irq.doubleFault)
    else $error("double request while disabled");
  AST_SGL_GATE: assert property (!err_q[0] |-> !irq.singleFault)
    else $error("single request while disabled");
  AST_LAUNCH: assert property (cmdLaunch |-> $past(wr && paddr == 16'hC09C && pwdata[7]))
    else $error("launch without write");
  AST_IGN_LEVEL: assert property (ignoreSingleFault == cfg_q[4])
    else $error("ignore level differs");
  cover property (arrayRead.readStrobe && cfg_q[1]);
  cover property (cmdLaunch);
  cover property (irq.cmdDone && cfg_q[7]);
endmodule
bind flash_fault_irq_config flash_fault_irq_config_props flash_fault_irq_config_props_inst (
  .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .arrayRead(arrayRead), .cmdFinish(cmdFinish), .cmdLaunch(cmdLaunch),
  .ignoreSingleFault(ignoreSingleFault), .irq(irq));

// *** verification/flash_array_model.sv ***
// Model of the flash array read path with its ECC checker
`timescale 1ns/1ps
module flash_array_model (
  input wire logic clk_sys, // Clock
  input wire logic rst, // Reset
  input wire logic doRead, // One array read wanted
  input wire logic [1:0] errIn, // Double and single ECC result
  output flash_fault_pkg::array_read_s arrayRead // Strobe and results
);
  flash_fault_pkg::array_read_s rdD;
  always_comb begin
    rdD.readStrobe = doRead;
    // Results mean nothing outside a strobe, so they toggle there
    rdD.doubleErr = doRead ? errIn[1] : !arrayRead.doubleErr;
    rdD.singleErr = doRead ? errIn[0] : !arrayRead.singleErr;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      arrayRead <= '0;
    end else begin
      arrayRead <= rdD;
    end
  end
endmodule

// *** verification/flash_fault_irq_config_bench.sv ***
// Self-checking bench for the flash fault configuration block
`timescale 1ns/1ps
module flash_fault_irq_config_bench;
  localparam logic [15:0] A_CFG = 16'hC090;
  localparam logic [15:0] A_ERR = 16'hC094;
  localparam logic [15:0] A_FLT = flash_fault_pkg::ADDR_FAULT_STATUS;
  localparam logic [15:0] A_FST = flash_fault_pkg::ADDR_FLASH_STATUS;
  logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, cmdFinish = 0, doRead = 0;
  logic [15:0] paddr = '0;
  logic [31:0] pwdata = '0, rd, prdata;
  logic [1:0] errIn = '0;
  logic pready, pslverr, cmdLaunch, ignoreSingleFault, errSeen;
  flash_fault_pkg::array_read_s arrayRead;
  flash_fault_pkg::irq_s irq;
  int errors = 0, n_checks = 0, cyc = 0;
  flash_fault_irq_config flash_fault_irq_config_inst (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .arrayRead(arrayRead), .cmdFinish(cmdFinish),
    .cmdLaunch(cmdLaunch), .ignoreSingleFault(ignoreSingleFault), .irq(irq));
  flash_array_model flash_array_model_inst (.clk_sys(clk_sys), .rst(rst), .doRead(doRead),
    .errIn(errIn), .arrayRead(arrayRead));
  always #20 clk_sys = ~clk_sys;
  task give_verdict();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      give_verdict();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    // Wait states are the slave's choice; the wait ends once pready is 1, or at the cycle ceiling if it never is
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    errSeen = pslverr;
    psel <= 0;
    penable <= 0;
    #1;
  endtask
  task rdchk(input logic [15:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    chk(rd, e);
  endtask
  task arr_read(input logic [1:0] e);
    @(posedge clk_sys);
    doRead <= 1;
    errIn <= e;
    @(posedge clk_sys);
    doRead <= 0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 0;
    rdchk(A_CFG, 32'h00);
    rdchk(A_ERR, 32'h00);
    rdchk(A_FST, 32'h80);
    apb(1, A_CFG, 32'hFF);
    rdchk(A_CFG, 32'h93);
    apb(1, A_ERR, 32'hFF);
    rdchk(A_ERR, 32'h03);
    rdchk(16'hC0A0, 32'h00);
    chk({31'h0, errSeen}, 32'h1);
    $display("test map done");
    arr_read(2'b00);
    chk({29'h0, irq}, 32'h7);
    rdchk(A_CFG, 32'h93);
    apb(1, A_FLT, 32'h03);
    chk({29'h0, irq}, 32'h4);
    apb(1, A_CFG, 32'h90);
    chk({31'h0, ignoreSingleFault}, 32'h1);
    arr_read(2'b01);
    rdchk(A_FLT, 32'h00);
    apb(1, A_CFG, 32'h00);
    arr_read(2'b00);
    rdchk(A_FLT, 32'h00);
    arr_read(2'b11);
    rdchk(A_FLT, 32'h03);
    chk({29'h0, irq}, 32'h3);
    apb(1, A_ERR, 32'h00);
    chk({29'h0, irq}, 32'h0);
    $display("test faults done");
    apb(1, A_CFG, 32'h80);
    chk({29'h0, irq}, 32'h4);
    apb(1, A_FST, 32'h80);
    chk({31'h0, cmdLaunch}, 32'h1);
    chk({29'h0, irq}, 32'h0);
    // A second launch while the command runs must be refused
    apb(1, A_FST, 32'h80);
    chk({31'h0, cmdLaunch}, 32'h0);
    rdchk(A_FST, 32'h00);
    @(posedge clk_sys);
    cmdFinish <= 1;
    @(posedge clk_sys);
    cmdFinish <= 0;
    @(posedge clk_sys);
    #1;
    chk({29'h0, irq}, 32'h4);
    $display("test command done");
    give_verdict();
  end
endmodule
